// ---- rtl/ict_timing.sv ----
// Purpose: b-address selection, cycle sharing and instruction cost
// Assumes: requests are single-cycle strobes synchronous to clk
// Notes: cost in milli-cycles so fractional figures stay exact
// Behaviour
// - a-only format: dup takes a, preserve keeps b
// - bypass paths never use b; only the ab bypass also leaves a alone
// - one cycle in four goes to processor
// - pcb costs +1 no branch, +2 taken
// - store control: w+4.33 or w+13
// - load control: w+4.33 or w+24
// - lca: 2n plus 5 even, 6 odd
// - mcw: 2n plus 6 even, 7 odd
// - branch and condition test: +4.5
// - character branches cost +6
// - lib: w+4.5 basic, 2w+6 relocation
// - sib: w+4 basic, 2w+5 relocation
// - svi: stored plus source plus 8
// - rvi costs +7
`timescale 1ns/1ps
`include "ict_params.svh"
module ict_timing #(
   parameter int ADDR_W = 18
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // address operand path
   input wire logic addr_valid,
   input wire logic a_only,
   input wire ict_pkg::ict_path_e path,
   input wire logic [ADDR_W-1:0] a_field,
   input wire logic [ADDR_W-1:0] b_field,
   // cost request; flag: taken, i/o, odd or relocation per op
   input wire logic cost_valid,
   input wire ict_pkg::ict_req_s cost_req,
   // results
   output logic [ADDR_W-1:0] a_address_register,
   output logic [ADDR_W-1:0] b_address_register,
   output logic cost_done,
   output logic [19:0] cost_milli,
   // memory cycle allocation
   output logic cpu_cycle,
   output logic io_cycle
);
   initial begin
      if (ADDR_W < 1 || ADDR_W > 32) $error("ict_timing: ADDR_W out of range");
   end
   // words to milli-cycles, used for every per-word term
   function automatic logic [19:0] to_milli(input logic [8:0] n);
      to_milli = 20'(n) * 20'(`ICT_MILLI);
   endfunction : to_milli
   // ===========================================
   // address registers
   logic [ADDR_W-1:0] next_a;
   logic [ADDR_W-1:0] next_b;
   always_comb begin
      next_a = a_address_register;
      next_b = b_address_register;
      if (addr_valid) begin
         case (path)
            ict_pkg::ICT_PATH_DUP_A: begin
               next_a = a_field;
               next_b = a_only ? a_field : b_field;
            end
            ict_pkg::ICT_PATH_PRESERVE_B: begin
               next_a = a_field;
               if (!a_only) next_b = b_field;
            end
            ict_pkg::ICT_PATH_BYPASS_B: begin
               next_a = a_field; // b left alone in any format
            end
            default: begin
               next_a = a_address_register; // neither touched
            end
         endcase
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         a_address_register <= '0;
         b_address_register <= '0;
      end else begin
         a_address_register <= next_a;
         b_address_register <= next_b;
      end
   end
   // ===========================================
   // cost computation
   // every term is in milli-cycles; 20 bits hold three full 255-word terms
   // plus the largest constant, so no sum below can wrap
   // flag meaning depends on the op:
   //    control branch      - branch taken
   //    control registers   - register belongs to i/o
   //    character moves     - field word count is odd
   //    index/barricade     - base relocation fitted
   logic [19:0] next_cost;
   logic [19:0] wi;
   logic [19:0] wf;
   logic [19:0] ws;
   logic [19:0] wr;
   logic f;
   always_comb begin
      wi = to_milli({1'b0, cost_req.instr_words});
      wf = to_milli({1'b0, cost_req.field_words});
      ws = to_milli({1'b0, cost_req.stored_words});
      wr = to_milli({1'b0, cost_req.source_words});
      f = cost_req.flag;
      next_cost = cost_milli;
      if (cost_valid) begin
         case (cost_req.op)
            ict_pkg::ICT_OP_PCB: begin
               // basic model: one cycle over length, two when it branches
               if (f) begin
                  next_cost = wi + `ICT_PCB_BR;
               end else begin
                  next_cost = wi + `ICT_PCB_NOBR;
               end
            end
            ict_pkg::ICT_OP_SCR: begin
               // an i/o register is far slower to store than a local one
               if (f) begin
                  next_cost = wi + wf + `ICT_SCR_IO;
               end else begin
                  next_cost = wi + wf + `ICT_CR_NONIO;
               end
            end
            ict_pkg::ICT_OP_LCR: begin
               // loading an i/o register costs more than storing it
               if (f) begin
                  next_cost = wi + wf + `ICT_LCR_IO;
               end else begin
                  next_cost = wi + wf + `ICT_CR_NONIO;
               end
            end
            ict_pkg::ICT_OP_LCA: begin
               // two cycles per field word; an odd count adds one more
               if (f) begin
                  next_cost = wi + wf + wf + `ICT_LCA_ODD;
               end else begin
                  next_cost = wi + wf + wf + `ICT_LCA_EVEN;
               end
            end
            ict_pkg::ICT_OP_MCW: begin
               // same shape as the a-mark load, one cycle dearer
               if (f) begin
                  next_cost = wi + wf + wf + `ICT_MCW_ODD;
               end else begin
                  next_cost = wi + wf + wf + `ICT_MCW_EVEN;
               end
            end
            ict_pkg::ICT_OP_BR, ict_pkg::ICT_OP_BCT: begin
               // plain branches: fixed overhead, taken or not
               next_cost = wi + `ICT_BR_SIMPLE;
            end
            ict_pkg::ICT_OP_BCC, ict_pkg::ICT_OP_BCE, ict_pkg::ICT_OP_BBE: begin
               // character branches fetch one operand character first
               next_cost = wi + `ICT_BR_CHAR;
            end
            ict_pkg::ICT_OP_LIB: begin
               // relocation moves a second register word
               if (f) begin
                  next_cost = wi + wf + wf + `ICT_LIB_RELOC;
               end else begin
                  next_cost = wi + wf + `ICT_LIB_BASIC;
               end
            end
            ict_pkg::ICT_OP_SIB: begin
               // store side of the index/barricade pair, half a cycle cheaper basic, one cycle cheaper with relocation
               if (f) begin
                  next_cost = wi + wf + wf + `ICT_SIB_RELOC;
               end else begin
                  next_cost = wi + wf + `ICT_SIB_BASIC;
               end
            end
            ict_pkg::ICT_OP_SVI: begin
               // stored words and source words both cost one cycle each
               next_cost = wi + ws + wr + `ICT_SVI_K;
            end
            ict_pkg::ICT_OP_RVI: begin
               // restore has a fixed overhead only
               next_cost = wi + `ICT_RVI_K;
            end
            // an unknown op still answers, so the caller never waits forever
            default: next_cost = 20'h00000; // unknown op costs nothing
         endcase
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cost_milli <= 20'h00000;
         cost_done <= 1'b0;
      end else begin
         cost_milli <= next_cost;
         cost_done <= cost_valid;
      end
   end
   // ===========================================
   // memory cycle sharing
   ict_slot_gen #(.SLOTS(`ICT_SLOT_COUNT)) u_slot (
      .clk(clk),
      .rstn(rstn),
      .cpu_cycle(cpu_cycle),
      .io_cycle(io_cycle)
   );
endmodule : ict_timing

// ---- rtl/ict_params.svh ----
// Purpose: constants for instruction cycle timing block
// Assumes: cycle figures kept in milli-cycles, fractional ones included
// Notes: fractional figures are scaled to milli-cycles for exact sums
`ifndef ICT_PARAMS_SVH
`define ICT_PARAMS_SVH
`define ICT_SLOT_COUNT 4
`define ICT_CPU_SLOT 2'h0
`define ICT_PCB_NOBR 20'h003e8
`define ICT_PCB_BR 20'h007d0
`define ICT_CR_NONIO 20'h010ea
`define ICT_SCR_IO 20'h032c8
`define ICT_LCR_IO 20'h05dc0
`define ICT_LCA_EVEN 20'h01388
`define ICT_LCA_ODD 20'h01770
`define ICT_MCW_EVEN 20'h01770
`define ICT_MCW_ODD 20'h01b58
`define ICT_BR_SIMPLE 20'h01194
`define ICT_BR_CHAR 20'h01770
`define ICT_LIB_BASIC 20'h01194
`define ICT_LIB_RELOC 20'h01770
`define ICT_SIB_BASIC 20'h00fa0
`define ICT_SIB_RELOC 20'h01388
`define ICT_SVI_K 20'h01f40
`define ICT_RVI_K 20'h01b58
`define ICT_MILLI 20'h003e8
`endif

// ---- rtl/ict_pkg.sv ----
// Purpose: types for instruction cycle timing block
// Assumes: nothing beyond the params header
// Notes: cost values are milli-memory-cycles
package ict_pkg;
   typedef enum logic [3:0] {
      ICT_OP_PCB = 4'h0, ICT_OP_SCR = 4'h1, ICT_OP_LCR = 4'h2, ICT_OP_LCA = 4'h3,
      ICT_OP_MCW = 4'h4, ICT_OP_BR = 4'h5, ICT_OP_BCT = 4'h6, ICT_OP_BCC = 4'h7,
      ICT_OP_BCE = 4'h8, ICT_OP_BBE = 4'h9, ICT_OP_LIB = 4'ha, ICT_OP_SIB = 4'hb,
      ICT_OP_SVI = 4'hc, ICT_OP_RVI = 4'hd
   } ict_op_e;
   typedef enum logic [1:0] {
      ICT_PATH_PRESERVE_B = 2'h0, ICT_PATH_DUP_A = 2'h1,
      ICT_PATH_BYPASS_B = 2'h2, ICT_PATH_BYPASS_AB = 2'h3
   } ict_path_e;
   typedef struct packed {
      ict_op_e op;
      logic [7:0] instr_words;
      logic [7:0] field_words;
      logic [7:0] stored_words;
      logic [7:0] source_words;
      logic flag;
   } ict_req_s;
endpackage : ict_pkg

// ---- rtl/ict_slot_gen.sv ----
// Purpose: memory cycle allocator, one processor slot in four
// Assumes: clk is the memory cycle
// Notes: slot counter free-runs from reset
`timescale 1ns/1ps
`include "ict_params.svh"
module ict_slot_gen #(
   parameter int SLOTS = `ICT_SLOT_COUNT
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // allocation
   output logic cpu_cycle,
   output logic io_cycle
);
   initial begin
      if (SLOTS != 4) $error("ict_slot_gen: only four-cycle groups served");
   end
   logic [1:0] slot;
   logic [1:0] next_slot;
   logic next_cpu;
   // ===========================================
   // slot counter
   always_comb begin
      next_slot = slot + 2'h1;
      next_cpu = (next_slot == `ICT_CPU_SLOT);
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         slot <= 2'h0;
         cpu_cycle <= 1'b0;
         io_cycle <= 1'b0;
      end else begin
         slot <= next_slot;
         cpu_cycle <= next_cpu;
         io_cycle <= ~next_cpu; // remaining three go to i/o
      end
   end
endmodule : ict_slot_gen

// ---- tb/ict_timing_chk.sv ----
// Purpose: port checker for ict_timing
// Assumes: one clock, rstn async active low
// Notes: costs are milli-cycles, one request answered a cycle later
`timescale 1ns/1ps
module ict_timing_chk #(
   parameter int ADDR_W = 18
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // requests
   input wire logic addr_valid,
   input wire logic a_only,
   input wire ict_pkg::ict_path_e path,
   input wire logic [ADDR_W-1:0] a_field,
   input wire logic cost_valid,
   input wire ict_pkg::ict_req_s cost_req,
   // results
   input wire logic [ADDR_W-1:0] a_address_register,
   input wire logic [ADDR_W-1:0] b_address_register,
   input wire logic cost_done,
   input wire logic [19:0] cost_milli,
   input wire logic cpu_cycle
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // instruction words scaled so fractional constants add exactly
   wire [19:0] w = 20'(cost_req.instr_words) * 20'h3e8;
   wire ict_pkg::ict_op_e op = cost_req.op;
   // ======================================================
   // cycle sharing and costs
   sequence s_io3;
      !cpu_cycle [*3] ##1 cpu_cycle;
   endsequence
   cpu_share_a: assert property (cpu_cycle |=> s_io3)
      else $error("processor slot spacing");
   cost_done_a: assert property (cost_valid |=> cost_done)
      else $error("cost answer missing");
   pcb_cost_a: assert property (cost_valid && op == ict_pkg::ICT_OP_PCB |=>
      cost_milli == $past(w) + ($past(cost_req.flag) ? 20'h7d0 : 20'h3e8))
      else $error("control branch cost");
   br_cost_a: assert property (cost_valid && op inside {ict_pkg::ICT_OP_BR,
      ict_pkg::ICT_OP_BCT} |=> cost_milli == $past(w) + 20'h1194)
      else $error("branch cost");
   chr_cost_a: assert property (cost_valid && op inside {ict_pkg::ICT_OP_BCC,
      ict_pkg::ICT_OP_BCE, ict_pkg::ICT_OP_BBE} |=> cost_milli == $past(w) + 20'h1770)
      else $error("character branch cost");
   rvi_cost_a: assert property (cost_valid && op == ict_pkg::ICT_OP_RVI |=>
      cost_milli == $past(w) + 20'h1b58)
      else $error("restore cost");
   // ======================================================
   // b address source
   dup_a_a: assert property (addr_valid && a_only && path == ict_pkg::ICT_PATH_DUP_A |=>
      b_address_register == $past(a_field))
      else $error("b not taken from a");
   keep_b_a: assert property (addr_valid && a_only &&
      path == ict_pkg::ICT_PATH_PRESERVE_B |=> $stable(b_address_register))
      else $error("b not preserved");
   bypass_ab_a: assert property (addr_valid && path == ict_pkg::ICT_PATH_BYPASS_AB |=>
      $stable(a_address_register) && $stable(b_address_register))
      else $error("bypass touched a register");
endmodule : ict_timing_chk

bind ict_timing ict_timing_chk #(.ADDR_W(ADDR_W)) chk (.clk, .rstn, .addr_valid, .a_only,
   .path, .a_field, .cost_valid, .cost_req, .a_address_register, .b_address_register,
   .cost_done, .cost_milli, .cpu_cycle);

// ---- tb/tb_ict_timing.sv ----
// Purpose: self-checking bench for ict_timing
// Assumes: clk 8 ns, rstn async active low
// Notes: rows hold costs for two instr words, field 4 plus flag, one stored and source word
`timescale 1ns/1ps
module tb_ict_timing;
   logic clk = 1'b0, rstn = 1'b0, addr_valid = 1'b0, a_only = 1'b0, cost_valid = 1'b0;
   ict_pkg::ict_path_e path = ict_pkg::ICT_PATH_PRESERVE_B;
   logic [17:0] a_field = 18'h0, b_field = 18'h0, a_reg, b_reg;
   ict_pkg::ict_req_s cost_req = '0;
   logic cost_done, cpu_cycle, io_cycle;
   logic [19:0] cost_milli;
   int fail_count = 0, compares = 0;
   int rows [14][2] = '{'{3000, 4000}, '{10330, 20000}, '{10330, 31000},
      '{15000, 18000}, '{16000, 19000}, '{6500, 6500}, '{6500, 6500},
      '{8000, 8000}, '{8000, 8000}, '{8000, 8000}, '{10500, 18000},
      '{10000, 17000}, '{12000, 12000}, '{9000, 9000}};
   ict_timing uut (.clk, .rstn, .addr_valid, .a_only, .path, .a_field, .b_field, .cost_valid,
      .cost_req, .a_address_register(a_reg), .b_address_register(b_reg), .cost_done,
      .cost_milli, .cpu_cycle, .io_cycle);
   // ======================================================
   // shared tasks
   task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // valid stays high so consecutive calls are back to back
   task automatic cost(input logic [3:0] op, input logic flag, input logic [19:0] exp);
      cost_valid = 1'b1;
      cost_req = '{ict_pkg::ict_op_e'(op), 8'h2, 8'h4 + 8'(flag), 8'h1, 8'h1, flag};
      @(posedge clk) #1;
      check("done", 20'h1, 20'(cost_done));
      check("cost", exp, cost_milli);
   endtask : cost
   task automatic addr(input logic only, input logic [1:0] p, input logic [17:0] a, ea, eb);
      addr_valid = 1'b1;
      a_only = only;
      path = ict_pkg::ict_path_e'(p);
      a_field = a;
      b_field = a + 18'h1;
      @(posedge clk) #1;
      check("a_reg", 20'(ea), 20'(a_reg));
      check("b_reg", 20'(eb), 20'(b_reg));
   endtask : addr
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   initial begin
      forever #4 clk = ~clk;
   end
   // sequence: rows, unknown op, address paths, reset and slot sharing
   initial begin
      repeat (6) @(posedge clk);
      #1 rstn = 1'b1;
      for (int i = 0; i < 28; i++) begin
         cost(i[4:1], i[0], 20'(rows[i[4:1]][i[0]]));
      end
      cost(4'he, 1'b0, 20'h0);
      $display("test costs done");
      cost_valid = 1'b0;
      addr(1'b0, 2'h0, 18'h5, 18'h5, 18'h6);
      addr(1'b1, 2'h1, 18'h11, 18'h11, 18'h11);
      addr(1'b1, 2'h0, 18'h22, 18'h22, 18'h11);
      addr(1'b1, 2'h3, 18'h33, 18'h22, 18'h11);
      addr(1'b0, 2'h2, 18'h55, 18'h55, 18'h11);
      addr_valid = 1'b0;
      $display("test address done");
      rstn = 1'b0;
      #1 check("rst cost", 20'h0, cost_milli);
      check("rst done", 20'h0, 20'(cost_done));
      check("rst a_reg", 20'h0, 20'(a_reg));
      check("rst b_reg", 20'h0, 20'(b_reg));
      @(posedge clk) #1 rstn = 1'b1;
      for (int i = 1; i < 9; i++) begin
         @(posedge clk) #1;
         check("cpu", 20'(i % 4 == 0), 20'(cpu_cycle));
         check("io", 20'(i % 4 != 0), 20'(io_cycle));
      end
      $display("test reset done");
      wrap_up();
   end
   // watchdog, the run needs under 100 cycles
   initial begin
      #5000;
      fail_count++;
      wrap_up();
   end
endmodule : tb_ict_timing
